// *** bench/fcw_master_model.sv ***
// Purpose: Fieldbus master model that drives the control word
// Assumes: Bench supplies the command bits; this model owns bit 11 and bit 15
// Notes:   Watchdog half period is scaled to a few cycles
`timescale 1ns/1ps
`default_nettype none

module fcw_master_model
   import fcw_pkg::*;
#(
   parameter int unsigned P_HALF = 8
)
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_wd_run,
   input wire logic [15:0] i_cmd,
   output fcw_ctrl_word_s o_word
);
   logic [15:0] half_q; // Cycles into the current half period
   logic wd_q; // Watchdog level sent to the drive

   // Square wave; stopping it models a dead master
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         half_q <= 16'h0000;
         wd_q <= 1'b0;
      end
      else if (i_wd_run && half_q == 16'(P_HALF - 1))
      begin
         half_q <= 16'h0000;
         wd_q <= ~wd_q;
      end
      else if (i_wd_run)
         half_q <= half_q + 16'h0001;
   end

   // Top bit held low so a fast-mode drive never sees it set
   assign o_word = {1'b0, i_cmd[14:12], wd_q, i_cmd[10:0]};
endmodule

`default_nettype wire

// *** bench/fcw_state_machine_monitor.sv ***
// Purpose: Port-level checks on the control word state machine
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Keeps its own copy of the sampled word to judge edges
`timescale 1ns/1ps
`default_nettype none

module fcw_state_machine_monitor
   import fcw_pkg::*;
#(
   parameter int unsigned P_WD_TICK_CYCLES = FCW_WD_TICK_CYCLES
)
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_cycle_tick,
   input wire fcw_ctrl_word_s i_fieldbus_control_word,
   input wire logic [2:0] i_control_place_select,
   input wire logic [15:0] i_wd_delay_ms,
   input wire logic i_fault_active,
   input wire logic i_at_zero_speed,
   input wire logic i_aux_jog_enable,
   input wire logic i_io_jog_enable,
   input wire fcw_drive_cmd_s o_drive_cmd,
   input wire fcw_state_e o_state,
   input wire logic o_fault_ack,
   input wire logic o_comm_fault,
   input wire logic o_fieldbus_active,
   input wire logic o_status_wd_echo
);
   fcw_ctrl_word_s w; // Shorthand for the incoming word
   fcw_ctrl_word_s prev_q; // Word taken at the last tick
   logic fb_tick; // Tick that the fieldbus may act on
   logic ack_rise; // Fault acknowledge edge seen at a tick
   logic on_rise; // Switch-on edge with both stops released

   assign w = i_fieldbus_control_word;
   assign fb_tick = i_cycle_tick && o_fieldbus_active && !i_fault_active;
   assign ack_rise = i_cycle_tick && o_fieldbus_active && w.fault_ack && !prev_q.fault_ack;
   assign on_rise = fb_tick && w.switch_on && !prev_q.switch_on && w.coast_stop_n
      && w.quick_stop_n;

   // Mirror of the sampled word; edges between ticks are invisible
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         prev_q <= FCW_WORD_RESET;
      else if (i_cycle_tick)
         prev_q <= w;
   end

   ////////////////////////////////////////
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_fb_place: assert property (o_fieldbus_active ==
      (i_control_place_select == FCW_PLACE_FIELDBUS && w.fb_enable)) else $error("place");
   a_wd_echo: assert property (o_status_wd_echo == prev_q.watchdog)
      else $error("echo");
   a_inhibit_exit: assert property (o_state == FCW_ST_READY_RUN &&
      $past(o_state) == FCW_ST_INHIBIT |-> $past(on_rise)) else $error("inhibit exit");
   a_ack_on_edge: assert property (ack_rise |=> o_fault_ack) else $error("ack");
   a_ack_only_edge: assert property (o_fault_ack |-> $past(ack_rise))
      else $error("ack level");
   a_coast_unpowered: assert property (o_drive_cmd.coast |-> !o_drive_cmd.modulate)
      else $error("coast");
   a_fb_drop_coast: assert property (o_state == FCW_ST_RUNNING && i_cycle_tick &&
      i_control_place_select == FCW_PLACE_FIELDBUS && !w.fb_enable && !i_fault_active
      |=> o_state == FCW_ST_STOPPING && o_drive_cmd.coast) else $error("fb drop");
   a_both_jog_stop: assert property (o_state == FCW_ST_JOG && fb_tick &&
      w.jog_one && w.jog_two |=> o_state == FCW_ST_STOPPING) else $error("both jog");
   a_jog_entry_ok: assert property (o_state == FCW_ST_JOG &&
      $past(o_state) != FCW_ST_JOG |-> $past(i_at_zero_speed &&
      (i_aux_jog_enable || i_io_jog_enable))) else $error("jog entry");
   a_wd_off_quiet: assert property (i_wd_delay_ms == FCW_WD_OFF && !o_comm_fault
      |=> !o_comm_fault) else $error("wd off");
   a_comm_fault_hold: assert property ($fell(o_comm_fault) |-> $past(ack_rise))
      else $error("comm fault");

   c_jog: cover property (o_state == FCW_ST_JOG);
   c_ack: cover property (o_fault_ack);
   c_comm: cover property ($rose(o_comm_fault));
endmodule

bind fcw_state_machine fcw_state_machine_monitor
   #(.P_WD_TICK_CYCLES(P_WD_TICK_CYCLES)) u_monitor (.*);

`default_nettype wire

// *** bench/fieldbus_control_word_state_machine_tb.sv ***
// Purpose: Self-checking bench for the control word state machine
// Assumes: Fieldbus is the control place except for one short check
// Notes:   Ticks run every cycle once started; watchdog ms shortened to 10 cycles
`timescale 1ns/1ps
`default_nettype none

module fieldbus_control_word_state_machine_tb
   import fcw_pkg::*;
;
   typedef struct packed {logic [15:0] w; logic z; logic a; fcw_state_e st;} fcw_row_s;
   logic i_clk, i_reset_n, i_cycle_tick, z, aux, fault, voff, jog_en, jog_one, wd_run;
   logic [2:0] place;
   logic [15:0] cmd, wd_delay;
   fcw_ctrl_word_s word;
   fcw_drive_cmd_s drive_cmd;
   fcw_state_e state;
   logic fault_ack, comm_fault, fb_active, wd_echo;
   int failures, checks, n;
   // Word, zero speed, aux jog enable, state expected after the tick
   fcw_row_s rows [21] = '{
      '{16'h0407, 1'b0, 1'b1, FCW_ST_READY_RUN},
      '{16'h047F, 1'b0, 1'b1, FCW_ST_RUNNING},
      '{16'h046F, 1'b0, 1'b1, FCW_ST_RUNNING},
      '{16'h0477, 1'b0, 1'b1, FCW_ST_STOPPING},
      '{16'h0477, 1'b1, 1'b1, FCW_ST_READY_RUN},
      '{16'h0476, 1'b1, 1'b1, FCW_ST_READY_ON},
      '{16'h0475, 1'b1, 1'b1, FCW_ST_INHIBIT},
      '{16'h0407, 1'b1, 1'b1, FCW_ST_INHIBIT},
      '{16'h0406, 1'b1, 1'b1, FCW_ST_INHIBIT},
      '{16'h0407, 1'b1, 1'b1, FCW_ST_READY_RUN},
      '{16'h0403, 1'b1, 1'b1, FCW_ST_INHIBIT},
      '{16'h0406, 1'b1, 1'b1, FCW_ST_INHIBIT},
      '{16'h0407, 1'b1, 1'b1, FCW_ST_READY_RUN},
      '{16'h0517, 1'b1, 1'b1, FCW_ST_READY_RUN},
      '{16'h0507, 1'b0, 1'b1, FCW_ST_READY_RUN},
      '{16'h0507, 1'b1, 1'b0, FCW_ST_READY_RUN},
      '{16'h0507, 1'b1, 1'b1, FCW_ST_JOG},
      '{16'h0707, 1'b1, 1'b1, FCW_ST_STOPPING},
      '{16'h0407, 1'b1, 1'b1, FCW_ST_READY_RUN},
      '{16'h047F, 1'b0, 1'b1, FCW_ST_RUNNING},
      '{16'h007F, 1'b0, 1'b1, FCW_ST_STOPPING}};

   fcw_master_model #(.P_HALF(8)) u_master (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_wd_run(wd_run), .i_cmd(cmd), .o_word(word));

   fcw_state_machine #(.P_WD_TICK_CYCLES(10)) DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_cycle_tick(i_cycle_tick), .i_fieldbus_control_word(word),
      .i_control_place_select(place), .i_quick_stop_mode(FCW_QS_RAMP),
      .i_stop_coast(1'b0), .i_wd_delay_ms(wd_delay), .i_fault_active(fault),
      .i_fault_voltage_off(voff), .i_at_zero_speed(z), .i_aux_jog_enable(aux),
      .i_io_jog_enable(jog_en), .i_io_jog_one(jog_one), .i_io_jog_two(1'b0),
      .i_io_run(1'b0), .o_drive_cmd(drive_cmd), .o_state(state), .o_fault_ack(fault_ack),
      .o_comm_fault(comm_fault), .o_fieldbus_active(fb_active), .o_status_wd_echo(wd_echo));

   // 125 MHz clock
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   // Compare and count; tick state is passed widened to 16 bits
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask

   // One control cycle; tick stays high so cycles run back to back
   task automatic step(input logic [15:0] w, input logic zs, input logic ae);
      cmd = w;
      z = zs;
      aux = ae;
      i_cycle_tick = 1'b1;
      @(posedge i_clk);
      #1;
   endtask

   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////
   initial
   begin
      {i_reset_n, i_cycle_tick, z, aux, fault, voff, jog_en, jog_one} = 8'h00;
      {cmd, wd_delay, failures, checks} = '0;
      wd_run = 1'b1;
      place = FCW_PLACE_FIELDBUS;
      repeat (12) @(posedge i_clk);
      #1;
      chk("reset state", {12'h000, FCW_ST_INHIBIT}, {12'h000, state});
      i_reset_n = 1'b1;
      foreach (rows[i])
      begin
         step(rows[i].w, rows[i].z, rows[i].a);
         chk("row state", {12'h000, rows[i].st}, {12'h000, state});
      end
      chk("coast", 16'h0001, {15'h0000, drive_cmd.coast});
      // Reset in mid-run, with a non-fieldbus place meanwhile
      i_reset_n = 1'b0;
      place = 3'h1;
      cmd = 16'h0406;
      @(posedge i_clk);
      #1;
      chk("fb active", 16'h0000, {15'h0000, fb_active});
      chk("reset cmd", 16'h0000, {7'h00, drive_cmd});
      chk("reset state", {12'h000, FCW_ST_INHIBIT}, {12'h000, state});
      place = FCW_PLACE_FIELDBUS;
      i_reset_n = 1'b1;
      step(16'h0407, 1'b1, 1'b0);
      jog_en = 1'b1;
      jog_one = 1'b1;
      step(16'h0407, 1'b1, 1'b0);
      chk("terminal jog", {12'h000, FCW_ST_JOG}, {12'h000, state});
      chk("jog one", 16'h0001, {15'h0000, drive_cmd.jog_one});
      step(16'h040F, 1'b1, 1'b0);
      chk("jog vs run", {12'h000, FCW_ST_STOPPING}, {12'h000, state});
      {jog_en, jog_one} = 2'b00;
      // External fault, acknowledged while still present, then a steady level
      fault = 1'b1;
      step(16'h0487, 1'b1, 1'b0);
      chk("ack pulse", 16'h0001, {15'h0000, fault_ack});
      fault = 1'b0;
      step(16'h0487, 1'b1, 1'b0);
      chk("ack level", 16'h0000, {15'h0000, fault_ack});
      chk("after fault", {12'h000, FCW_ST_READY_ON}, {12'h000, state});
      // Watchdog: live master, then supervision off, then silent master
      wd_delay = 16'h0003;
      repeat (100) @(posedge i_clk);
      #1;
      chk("wd live", 16'h0000, {15'h0000, comm_fault});
      wd_run = 1'b0;
      wd_delay = FCW_WD_OFF;
      repeat (100) @(posedge i_clk);
      #1;
      chk("wd off", 16'h0000, {15'h0000, comm_fault});
      chk("echo", {15'h0000, word.watchdog}, {15'h0000, wd_echo});
      wd_delay = 16'h0003;
      n = 0;
      while (comm_fault !== 1'b1 && n < 80)
      begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk("wd lost", 16'h0001, {15'h0000, comm_fault});
      step(16'h0407, 1'b1, 1'b0);
      chk("wd state", {12'h000, FCW_ST_FAULT}, {12'h000, state});
      wd_delay = FCW_WD_OFF;
      wd_run = 1'b1;
      step(16'h0487, 1'b1, 1'b0);
      chk("comm ack", 16'h0001, {15'h0000, fault_ack});
      chk("comm clear", 16'h0000, {15'h0000, comm_fault});
      step(16'h0487, 1'b1, 1'b0);
      chk("volt off", {12'h000, FCW_ST_INHIBIT}, {12'h000, state});
      results();
   end
endmodule

`default_nettype wire

// *** src/fcw_pkg.sv ***
// Purpose: Shared types and constants for the fieldbus control word state machine
// Assumes: 16-bit control word, drive control cycle marked by a one-cycle tick
// Notes:   Field layout of the control word is fixed by the packed struct below
package fcw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Constants

   // Control-place selection value that hands control to the fieldbus
   localparam logic [2:0] FCW_PLACE_FIELDBUS = 3'h3;
   // Sampled control word after reset: every stop active, nothing requested
   localparam logic [15:0] FCW_WORD_RESET = 16'h0000;
   // Watchdog delay setting meaning supervision off
   localparam logic [15:0] FCW_WD_OFF = 16'h0000;
   // Clock period and watchdog time base
   localparam int unsigned FCW_CLK_PERIOD_NS = 8;
   localparam int unsigned FCW_WD_TICK_NS = 1_000_000;
   // Cycles per watchdog millisecond, rounded down
   localparam int unsigned FCW_WD_TICK_CYCLES = FCW_WD_TICK_NS / FCW_CLK_PERIOD_NS;
   // Reset value of the watchdog millisecond counters
   localparam logic [16:0] FCW_CNT_RESET = 17'h0_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Types

   // Stop behaviour chosen by the quick-stop configuration setting
   typedef enum logic [1:0]
   {
      FCW_QS_RAMP,
      FCW_QS_FAST_RAMP,
      FCW_QS_COAST
   } fcw_qs_mode_e;

   // Drive states
   typedef enum logic [3:0]
   {
      FCW_ST_INHIBIT,
      FCW_ST_READY_ON,
      FCW_ST_READY_RUN,
      FCW_ST_RUNNING,
      FCW_ST_STOPPING,
      FCW_ST_QUICK_STOP,
      FCW_ST_JOG,
      FCW_ST_FAULT
   } fcw_state_e;

   // Control word, bit 15 down to bit 0
   typedef struct packed
   {
      logic reserved;
      logic bus_digital_in_four;
      logic bus_digital_in_three;
      logic bus_digital_in_two;
      logic watchdog;
      logic fb_enable;
      logic jog_two;
      logic jog_one;
      logic fault_ack;
      logic setpoint_enable;
      logic ramp_unfreeze;
      logic ramp_enable;
      logic start;
      logic quick_stop_n;
      logic coast_stop_n;
      logic switch_on;
   } fcw_ctrl_word_s;

   // Commands to the motor control path
   typedef struct packed
   {
      logic modulate;
      logic coast;
      logic ramp_stop;
      logic fast_ramp;
      logic ramp_out_zero;
      logic ramp_hold;
      logic setpoint_zero;
      logic jog_one;
      logic jog_two;
   } fcw_drive_cmd_s;

endpackage

// *** src/fcw_state_machine.sv ***
// Purpose: Decode the fieldbus control word and run the drive state machine
// Assumes: All inputs synchronous to i_clk; i_cycle_tick marks each control cycle
// Notes:   Word is sampled only on i_cycle_tick; edges are taken against the
//          previous sample, so edge bits must stand for at least one control cycle
//
// Functional notes
// - Switch-on rising edge leaves inhibit to ready-run
// - Switch-on low: ramp stop, then ready-to-switch-on
// - Coast-stop low: coast, enter switch-on inhibit
// - Quick-stop low: configured quick-stop behaviour
// - Run bit starts; low stops by stop function
// - Ramp-release low forces ramp output zero
// - Ramp-release beats freeze beats setpoint enable
// - Ramp-freeze low holds speed, ignores new reference
// - Setpoint-enable low forces reference zero
// - Fault acknowledged only on rising edge
// - Voltage removed by fault: inhibit after acknowledge
// - Each jog bit runs its own jog reference
// - Fieldbus jog needs all ramp bits zero
// - Jog accepted only at zero speed
// - Ramp bits act again after jog reaches zero
// - Jogging needs separate enable input
// - Terminal jog starts without separate run command
// - Jogging blocked while run command present
// - Both jog requests together stop the drive
// - Fieldbus enable acts only with fieldbus place
// - Missing watchdog toggling raises communication fault
// - Fieldbus enable removed while running: coast stop
// - Zero watchdog delay disables supervision
// - Received watchdog bit echoed in status top bit
`timescale 1ns/1ps
`default_nettype none

module fcw_state_machine
   import fcw_pkg::*;
#(
   // Clock cycles per watchdog millisecond; shorten for simulation
   parameter int unsigned P_WD_TICK_CYCLES = FCW_WD_TICK_CYCLES
)
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_cycle_tick,
   input wire fcw_ctrl_word_s i_fieldbus_control_word,
   input wire logic [2:0] i_control_place_select,
   input wire fcw_qs_mode_e i_quick_stop_mode,
   input wire logic i_stop_coast,
   input wire logic [15:0] i_wd_delay_ms,
   input wire logic i_fault_active,
   input wire logic i_fault_voltage_off,
   input wire logic i_at_zero_speed,
   input wire logic i_aux_jog_enable,
   input wire logic i_io_jog_enable,
   input wire logic i_io_jog_one,
   input wire logic i_io_jog_two,
   input wire logic i_io_run,
   output fcw_drive_cmd_s o_drive_cmd,
   output fcw_state_e o_state,
   output logic o_fault_ack,
   output logic o_comm_fault,
   output logic o_fieldbus_active,
   output logic o_status_wd_echo
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   fcw_ctrl_word_s word_q;         // Word sampled at the last control cycle
   fcw_ctrl_word_s cur;            // Word seen in this cycle
   fcw_state_e state_q, state_d; // Drive state
   fcw_state_e stop_target_q, stop_target_d; // Where a ramp or coast stop settles
   fcw_drive_cmd_s cmd_q, cmd_d; // Registered drive commands
   logic stop_coast_q, stop_coast_d; // Current stop runs by coasting
   logic volt_off_q;               // Fault reaction removed output voltage
   logic jog_mask_q;               // Ramp bits masked until jog has stopped
   logic comm_fault_q;             // Watchdog communication fault, sticky
   logic fault_ack_q;              // One-cycle acknowledge pulse
   logic fb_active;                // Fieldbus owns the control word
   logic fb_place;                 // Control place is the fieldbus
   logic on_rise;                  // Switch-on bit 0 to 1
   logic ack_rise;                 // Fault acknowledge bit 0 to 1
   logic wd_toggle;                // Watchdog bit changed since last sample
   logic fault_now;                // Any fault holding the drive
   logic ramp_bits_zero;           // All three ramp-control bits low
   logic fb_jog_req;               // Fieldbus asks for jogging
   logic io_jog_req;               // Terminals ask for jogging
   logic both_jog;                 // Both jog references requested
   logic run_cmd;                  // Run command from the active place
   logic jog_ok;                   // Jog may be accepted now
   logic [16:0] tick_cnt_q;        // Cycles within one millisecond
   logic [16:0] wd_ms_q;           // Milliseconds since last watchdog toggle
   logic ms_tick;                  // One-cycle millisecond pulse
   logic wd_timeout;               // Watchdog delay exceeded

   ////////////////////////////////////////////////////////////////////////////
   // Sampling and edge detection
   // Sample once per control cycle; edges compare against the last sample
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         word_q <= fcw_ctrl_word_s'(FCW_WORD_RESET);
      else if (i_cycle_tick)
         word_q <= i_fieldbus_control_word;
   end

   // Edges exist only in the tick cycle, so a held level never re-fires
   always_comb
   begin
      cur = i_fieldbus_control_word;
      fb_place = (i_control_place_select == FCW_PLACE_FIELDBUS);
      fb_active = fb_place && cur.fb_enable;
      on_rise = i_cycle_tick && cur.switch_on && !word_q.switch_on;
      ack_rise = i_cycle_tick && cur.fault_ack && !word_q.fault_ack;
      wd_toggle = i_cycle_tick && (cur.watchdog != word_q.watchdog);
      fault_now = i_fault_active || comm_fault_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Jog qualification
   // Jog requests and acceptance conditions
   always_comb
   begin
      ramp_bits_zero = !cur.ramp_enable && !cur.ramp_unfreeze && !cur.setpoint_enable;
      fb_jog_req = fb_active && (cur.jog_one || cur.jog_two) && ramp_bits_zero;
      // Terminal jog needs its own enable and no run command
      io_jog_req = i_io_jog_enable && (i_io_jog_one || i_io_jog_two);
      both_jog = (fb_active && cur.jog_one && cur.jog_two) || (i_io_jog_one && i_io_jog_two);
      run_cmd = (fb_active && cur.start) || (!fb_place && i_io_run);
      // Fieldbus jog also needs the auxiliary enable
      jog_ok = ((fb_jog_req && i_aux_jog_enable) || io_jog_req)
         && i_at_zero_speed && !run_cmd && !both_jog;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State machine
   // Next state and stop style; fault entry acts in any cycle, the rest once per control cycle
   always_comb
   begin
      state_d = state_q;
      stop_target_d = stop_target_q;
      stop_coast_d = stop_coast_q;
      if (fault_now)
         state_d = FCW_ST_FAULT;
      else if (i_cycle_tick)
      begin
         unique case (state_q)
            FCW_ST_FAULT: state_d = volt_off_q ? FCW_ST_INHIBIT : FCW_ST_READY_ON;
            FCW_ST_INHIBIT:
               // Leave only on a fresh switch-on with no stop bit active
               if (fb_active && on_rise && cur.coast_stop_n && cur.quick_stop_n)
                  state_d = FCW_ST_READY_RUN;
            FCW_ST_READY_ON:
               if (fb_active && !cur.coast_stop_n)
                  state_d = FCW_ST_INHIBIT;
               else if (fb_active && !cur.quick_stop_n)
                  state_d = FCW_ST_INHIBIT;
               else if (io_jog_req && jog_ok)
                  state_d = FCW_ST_JOG;
               else if (fb_active && cur.switch_on)
                  state_d = FCW_ST_READY_RUN;
            FCW_ST_READY_RUN:
               if (fb_active && !cur.coast_stop_n)
                  state_d = FCW_ST_INHIBIT;
               else if (fb_active && !cur.quick_stop_n)
                  state_d = FCW_ST_INHIBIT;
               else if (!fb_active || !cur.switch_on)
                  state_d = FCW_ST_READY_ON;
               else if (jog_ok)
                  state_d = FCW_ST_JOG;
               else if (cur.start)
                  state_d = FCW_ST_RUNNING;
            FCW_ST_RUNNING, FCW_ST_JOG:
               if (fb_place && !cur.fb_enable)
               begin
                  // Losing fieldbus control mid-run coasts
                  state_d = FCW_ST_STOPPING;
                  stop_target_d = FCW_ST_READY_ON;
                  stop_coast_d = 1'b1;
               end
               else if (fb_active && !cur.coast_stop_n)
               begin
                  state_d = FCW_ST_STOPPING;
                  stop_target_d = FCW_ST_INHIBIT;
                  stop_coast_d = 1'b1;
               end
               else if (fb_active && !cur.quick_stop_n)
                  state_d = FCW_ST_QUICK_STOP;
               else if (fb_active && !cur.switch_on)
               begin
                  state_d = FCW_ST_STOPPING;
                  stop_target_d = FCW_ST_READY_ON;
                  stop_coast_d = 1'b0;
               end
               else if (state_q == FCW_ST_RUNNING && !cur.start)
               begin
                  state_d = FCW_ST_STOPPING;
                  stop_target_d = FCW_ST_READY_RUN;
                  stop_coast_d = i_stop_coast;
               end
               else if (state_q == FCW_ST_JOG
                  && (both_jog || run_cmd || !(fb_jog_req || io_jog_req)))
               begin
                  // Jog ends or is blocked: ramp down
                  state_d = FCW_ST_STOPPING;
                  stop_target_d = fb_active ? FCW_ST_READY_RUN : FCW_ST_READY_ON;
                  stop_coast_d = 1'b0;
               end
            FCW_ST_STOPPING:
               if (i_at_zero_speed)
                  state_d = stop_target_q;
            FCW_ST_QUICK_STOP:
               // Emergency stop always ends in inhibit, needing a new switch-on
               if (i_at_zero_speed)
                  state_d = FCW_ST_INHIBIT;
         endcase
      end
   end

   // State registers
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_q <= FCW_ST_INHIBIT;
         stop_target_q <= FCW_ST_INHIBIT;
         stop_coast_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         stop_target_q <= stop_target_d;
         stop_coast_q <= stop_coast_d;
      end
   end

   // Remember whether the fault reaction cut the output voltage
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         volt_off_q <= 1'b0;
      else if (fault_now)
         volt_off_q <= i_fault_voltage_off || comm_fault_q;
   end

   // Ramp bits stay masked from jog entry until the drive is back at zero
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         jog_mask_q <= 1'b0;
      else if (state_q == FCW_ST_JOG)
         jog_mask_q <= 1'b1;
      else if (i_at_zero_speed && state_q != FCW_ST_STOPPING)
         jog_mask_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drive commands
   // Decode state and ramp bits into the motor control commands
   always_comb
   begin
      cmd_d = '0;
      unique case (state_d)
         FCW_ST_RUNNING:
         begin
            cmd_d.modulate = 1'b1;
            // Fixed priority: release, then freeze, then setpoint
            if (jog_mask_q)
               cmd_d.setpoint_zero = 1'b1;
            else if (!cur.ramp_enable)
               cmd_d.ramp_out_zero = 1'b1;
            else if (!cur.ramp_unfreeze)
               cmd_d.ramp_hold = 1'b1;
            else if (!cur.setpoint_enable)
               cmd_d.setpoint_zero = 1'b1;
         end
         FCW_ST_JOG:
         begin
            cmd_d.modulate = 1'b1;
            cmd_d.jog_one = (fb_active && cur.jog_one) || i_io_jog_one;
            cmd_d.jog_two = (fb_active && cur.jog_two) || i_io_jog_two;
         end
         FCW_ST_STOPPING:
         begin
            // Coasting removes modulation at once; ramping keeps it
            cmd_d.coast = stop_coast_d;
            cmd_d.modulate = !stop_coast_d;
            cmd_d.ramp_stop = !stop_coast_d;
         end
         FCW_ST_QUICK_STOP:
         begin
            cmd_d.coast = (i_quick_stop_mode == FCW_QS_COAST);
            cmd_d.modulate = (i_quick_stop_mode != FCW_QS_COAST);
            cmd_d.ramp_stop = (i_quick_stop_mode == FCW_QS_RAMP);
            cmd_d.fast_ramp = (i_quick_stop_mode == FCW_QS_FAST_RAMP);
         end
         default: cmd_d.coast = 1'b0;
      endcase
   end

   // Commands leave from flip-flops
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         cmd_q <= '0;
      else
         cmd_q <= cmd_d;
   end

   // Acknowledge pulse: edge only, a held bit does nothing
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         fault_ack_q <= 1'b0;
      else
         fault_ack_q <= fb_active && ack_rise;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog supervision
   // Free-running millisecond time base
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         tick_cnt_q <= FCW_CNT_RESET;
      else if (ms_tick)
         tick_cnt_q <= FCW_CNT_RESET;
      else
         tick_cnt_q <= tick_cnt_q + 17'h0_0001;
   end

   // Millisecond pulse and timeout against the configured delay
   assign ms_tick = (tick_cnt_q >= 17'(P_WD_TICK_CYCLES - 1));
   assign wd_timeout = fb_active && (i_wd_delay_ms != FCW_WD_OFF)
      && (wd_ms_q >= {1'b0, i_wd_delay_ms});

   // Milliseconds since the watchdog bit last changed; idle when off
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         wd_ms_q <= FCW_CNT_RESET;
      else if (wd_toggle || !fb_active || i_wd_delay_ms == FCW_WD_OFF)
         wd_ms_q <= FCW_CNT_RESET;
      else if (ms_tick && !wd_timeout)
         wd_ms_q <= wd_ms_q + 17'h0_0001;
   end

   // Sticky fault; a timeout in the acknowledge cycle wins over the clear
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         comm_fault_q <= 1'b0;
      else if (wd_timeout)
         comm_fault_q <= 1'b1;
      else if (fb_active && ack_rise)
         comm_fault_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_drive_cmd = cmd_q;
   assign o_state = state_q;
   assign o_fault_ack = fault_ack_q;
   assign o_comm_fault = comm_fault_q;
   assign o_fieldbus_active = fb_active;
   assign o_status_wd_echo = word_q.watchdog;

endmodule
`default_nettype wire
